/* hw/lcc_device.sv */
/*
  Secondary cache control logic: tag store, fill and flush sequencing,
  inhibit, power-down and soft-reset handling. Assumes the system stops
  the clock during power-down and holds hard reset long enough.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lcc_defines.svh"

// Contract
// - Miss-fill inhibit blocks allocation on misses.
// - Tag clear invalidates all, holds reset.
// - Update disable ignores bus, freezes state.
// - Power-down blocks array address/data changes.
// - Resume only after wake-up interval.
// - System stops clock during power-down.
// - Soft reset synchronised within 8-16 cycles.
// - Soft reset returns transfer machine idle.
// - Grounded strap forces write-through only.
// - Unused test reset held low.
// - Burst status separates burst from single.
// - Transfer start opens each cycle, decode.
// - Cache inhibit sampled after start, no fill.
// - Flush writes back dirty, clears valid.
// - Hard reset held low 16 cycles.
module lcc_device
  import lcc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int LINES  = 4
)(
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_resetn,
  // Bus
  lcc_bus_if.device              bus,
  // Array side
  output logic                   o_array_we,
  output logic [ADDR_W-1:0]      o_array_addr,
  output logic                   o_fill,
  output logic                   o_writeback,
  output logic [ADDR_W-1:0]      o_wb_addr,
  // Status
  output logic                   o_hit,
  output logic                   o_ready,
  output logic                   o_write_through,
  output logic                   o_soft_reset,
  output logic                   o_flush_busy
);

  localparam int IDX_W = $clog2(LINES);
  localparam int TAG_W = ADDR_W - IDX_W;
  localparam int SQ_W  = 5;
  localparam int WK_W  = $clog2(`LCC_WAKE_CYC + 1);
  localparam int BT_W  = $clog2(`LCC_BURST_BEATS + 1);
  localparam logic [SQ_W-1:0] SRST_QUAL = SQ_W'(`LCC_SRST_QUAL_CYC);
  localparam logic [WK_W-1:0] WAKE_CYC  = WK_W'(`LCC_WAKE_CYC);
  localparam logic [BT_W-1:0] BURST_CYC = BT_W'(`LCC_BURST_BEATS);
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(LINES - 1);

  // ============================================================
  // Control pin synchronisers
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;

  assign pin_raw = {bus.miss_fill_inhibit_n, bus.tag_clear_all_n, bus.cache_update_disable_n,
                    bus.power_down_request_n, bus.soft_reset_in_n, bus.flush_request_n};

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sync1_r <= '1;
      sync2_r <= '1;
    end
    else
    begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
    end
  end

  logic miss_inh;
  logic tag_clr;
  logic upd_dis;
  logic pwr_dn;
  logic srst_s;
  logic flush_s;

  assign miss_inh = ~sync2_r[5];
  assign tag_clr  = ~sync2_r[4];
  assign upd_dis  = ~sync2_r[3];
  assign pwr_dn   = ~sync2_r[2];
  assign srst_s   = ~sync2_r[1];
  assign flush_s  = ~sync2_r[0];

  // Write-through strap, sampled through the same two stages
  logic wt1_r;
  logic wt2_r;

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wt1_r <= 1'b1;
      wt2_r <= 1'b1;
    end
    else
    begin
      wt1_r <= bus.write_through_strap;
      wt2_r <= wt1_r;
    end
  end

  assign o_write_through = ~wt2_r;

  // ============================================================
  // Soft reset qualification
  logic [SQ_W-1:0] srst_cnt_r;
  logic            srst_act;

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      srst_cnt_r <= '0;
    else if (!srst_s)
      srst_cnt_r <= '0;
    else if (srst_cnt_r != SRST_QUAL)
      srst_cnt_r <= srst_cnt_r + SQ_W'(1);
  end

  assign srst_act     = (srst_cnt_r == SRST_QUAL);
  assign o_soft_reset = srst_act;

  // ============================================================
  // Power-down and wake-up
  logic [WK_W-1:0] wake_cnt_r;
  logic            awake;

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      wake_cnt_r <= WAKE_CYC;
    else if (pwr_dn)
      wake_cnt_r <= '0;
    else if (wake_cnt_r != WAKE_CYC)
      wake_cnt_r <= wake_cnt_r + WK_W'(1);
  end

  assign awake   = !pwr_dn && (wake_cnt_r == WAKE_CYC);
  assign o_ready = awake && !tag_clr && !upd_dis;

  // ============================================================
  // Transfer decode
  logic              ts;
  logic              is_write;
  logic [IDX_W-1:0]  idx;
  logic [TAG_W-1:0]  tag_in;

  assign ts       = !bus.transfer_start_n;
  assign is_write = (bus.transfer_type == `LCC_TT_WRITE);
  assign idx      = bus.transfer_addr[IDX_W-1:0];
  assign tag_in   = bus.transfer_addr[ADDR_W-1:IDX_W];

  // ============================================================
  // Transfer state machine and tag store
  lcc_state_t        state_r;
  logic [LINES-1:0]  valid_r;
  logic [LINES-1:0]  dirty_r;
  logic [TAG_W-1:0]  tag_r [LINES];
  logic [ADDR_W-1:0] cur_addr_r;
  logic              cur_write_r;
  logic              cur_burst_r;
  logic [BT_W-1:0]   beat_r;
  logic [IDX_W-1:0]  fl_idx_r;
  logic              flush_q_r;
  logic              ack_r;
  logic              hit_r;
  logic              fill_r;
  logic              wb_r;
  logic [ADDR_W-1:0] wb_addr_r;
  logic              cur_hit;
  logic [IDX_W-1:0]  cur_idx;

  assign cur_idx = cur_addr_r[IDX_W-1:0];
  assign cur_hit = valid_r[cur_idx] && (tag_r[cur_idx] == cur_addr_r[ADDR_W-1:IDX_W]);

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_r     <= LCC_ST_IDLE;
      valid_r     <= '0;
      dirty_r     <= '0;
      cur_addr_r  <= '0;
      cur_write_r <= 1'b0;
      cur_burst_r <= 1'b0;
      beat_r      <= '0;
      fl_idx_r    <= '0;
      flush_q_r   <= 1'b0;
      ack_r       <= 1'b0;
      hit_r       <= 1'b0;
      fill_r      <= 1'b0;
      wb_r        <= 1'b0;
      wb_addr_r   <= '0;
      for (int i = 0; i < LINES; i++)
        tag_r[i] <= '0;
    end
    else if (tag_clr)
    begin
      state_r   <= LCC_ST_IDLE;
      valid_r   <= '0;
      dirty_r   <= '0;
      flush_q_r <= 1'b0;
      ack_r     <= 1'b0;
      hit_r     <= 1'b0;
      fill_r    <= 1'b0;
      wb_r      <= 1'b0;
    end
    else if (srst_act)
    begin
      state_r <= LCC_ST_IDLE;
      ack_r   <= 1'b0;
      fill_r  <= 1'b0;
      wb_r    <= 1'b0;
    end
    else if (!upd_dis)
    begin
      ack_r  <= 1'b0;
      fill_r <= 1'b0;
      wb_r   <= 1'b0;
      flush_q_r <= flush_s;
      case (state_r)
        LCC_ST_IDLE:
        begin
          if (flush_s && !flush_q_r)
          begin
            fl_idx_r <= '0;
            state_r  <= LCC_ST_FLUSH;
          end
          else if (ts && awake)
          begin
            cur_addr_r  <= bus.transfer_addr;
            cur_write_r <= is_write;
            cur_burst_r <= !bus.burst_status_n;
            state_r     <= LCC_ST_LOOK;
          end
        end
        LCC_ST_LOOK:
        begin
          hit_r <= cur_hit;
          if (cur_hit)
          begin
            if (cur_write_r && wt2_r)
              dirty_r[cur_idx] <= 1'b1;
            state_r <= LCC_ST_ACK;
          end
          else if (!cur_write_r && !miss_inh && bus.cache_inhibit_in_n)
          begin
            beat_r  <= cur_burst_r ? BURST_CYC : BT_W'(1);
            state_r <= LCC_ST_FILL;
          end
          else
            state_r <= LCC_ST_ACK;
        end
        LCC_ST_FILL:
        begin
          fill_r <= 1'b1;
          if (beat_r == BT_W'(1))
          begin
            valid_r[cur_idx] <= 1'b1;
            dirty_r[cur_idx] <= 1'b0;
            tag_r[cur_idx]   <= cur_addr_r[ADDR_W-1:IDX_W];
            state_r          <= LCC_ST_ACK;
          end
          beat_r <= beat_r - BT_W'(1);
        end
        LCC_ST_ACK:
        begin
          ack_r   <= 1'b1;
          state_r <= LCC_ST_IDLE;
        end
        LCC_ST_FLUSH:
        begin
          if (dirty_r[fl_idx_r])
          begin
            wb_r              <= 1'b1;
            wb_addr_r         <= {tag_r[fl_idx_r], fl_idx_r};
            dirty_r[fl_idx_r] <= 1'b0;
          end
          if (fl_idx_r == LAST_IDX)
          begin
            valid_r <= '0;
            state_r <= LCC_ST_IDLE;
          end
          fl_idx_r <= fl_idx_r + IDX_W'(1);
        end
        default:
        begin
          state_r <= LCC_ST_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // Array port, frozen while powered down
  logic [ADDR_W-1:0] arr_addr_r;
  logic              arr_we_r;

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      arr_addr_r <= '0;
      arr_we_r   <= 1'b0;
    end
    else if (pwr_dn)
      arr_we_r <= 1'b0;
    else
    begin
      arr_we_r <= (state_r == LCC_ST_FILL) && !tag_clr && !upd_dis && !srst_act;
      if (state_r == LCC_ST_FILL || state_r == LCC_ST_LOOK)
        arr_addr_r <= cur_addr_r;
    end
  end

  assign o_array_we         = arr_we_r;
  assign o_array_addr       = arr_addr_r;
  assign o_fill             = fill_r;
  assign o_writeback        = wb_r;
  assign o_wb_addr          = wb_addr_r;
  assign o_hit              = hit_r;
  assign o_flush_busy       = (state_r == LCC_ST_FLUSH);
  assign bus.transfer_ack_n = ~ack_r;

endmodule : lcc_device

`default_nettype wire

/* pkg/lcc_defines.svh */
/*
  Timing counts, pin encodings and reset values for the secondary cache
  control block. Assumes a 20 MHz system clock.
*/
`ifndef LCC_DEFINES_SVH
`define LCC_DEFINES_SVH

// ============================================================
// Clock and timing
`define LCC_CLK_PERIOD_NS   50
`define LCC_WAKE_TIME_NS    4000
`define LCC_WAKE_CYC        ((`LCC_WAKE_TIME_NS + `LCC_CLK_PERIOD_NS - 1) / `LCC_CLK_PERIOD_NS)
`define LCC_SRST_MIN_CYC    8
`define LCC_SRST_MAX_CYC    16
`define LCC_SYNC_STAGES     2
`define LCC_SRST_QUAL_CYC   (`LCC_SRST_MIN_CYC - `LCC_SYNC_STAGES)
`define LCC_HRST_MIN_CYC    16

// ============================================================
// Bus encodings
`define LCC_TT_READ         5'h0A
`define LCC_TT_WRITE        5'h02
`define LCC_TSIZ_BEAT       3'h0
`define LCC_TSIZ_BURST      3'h2
`define LCC_BURST_BEATS     4

`endif

/* pkg/lcc_pkg.sv */
/*
  Types shared by both ends of the secondary cache control link.
  Assumes lcc_defines.svh for the numeric constants.
*/
`default_nettype none

package lcc_pkg;

  // ============================================================
  // Device transfer state machine
  typedef enum logic [2:0] {
    LCC_ST_IDLE,
    LCC_ST_LOOK,
    LCC_ST_FILL,
    LCC_ST_ACK,
    LCC_ST_FLUSH
  } lcc_state_t;

  // ============================================================
  // Host transfer state machine
  typedef enum logic [1:0] {
    LCC_HS_IDLE,
    LCC_HS_WAIT
  } lcc_hstate_t;

endpackage : lcc_pkg

`default_nettype wire

/* pkg/lcc_bus_if.sv */
/*
  Processor-bus and control pins between the cache device and the bus
  master. Assumes both ends share one clock; strobes and control pins are active low.
*/
`timescale 1ns/1ps
`default_nettype none

interface lcc_bus_if #(
  parameter int ADDR_W = 8
);
  logic              transfer_start_n;
  logic              burst_status_n;
  logic [2:0]        transfer_size;
  logic [4:0]        transfer_type;
  logic [ADDR_W-1:0] transfer_addr;
  logic              cache_inhibit_in_n;
  logic              transfer_ack_n;
  logic              miss_fill_inhibit_n;
  logic              tag_clear_all_n;
  logic              cache_update_disable_n;
  logic              power_down_request_n;
  logic              soft_reset_in_n;
  logic              write_through_strap;
  logic              flush_request_n;
  logic              scan_reset_n;

  modport device (
    input  transfer_start_n, burst_status_n, transfer_size, transfer_type, transfer_addr,
    input  cache_inhibit_in_n, miss_fill_inhibit_n, tag_clear_all_n, cache_update_disable_n,
    input  power_down_request_n, soft_reset_in_n, write_through_strap, flush_request_n,
    output transfer_ack_n
  );

  modport host (
    output transfer_start_n, burst_status_n, transfer_size, transfer_type, transfer_addr,
    output cache_inhibit_in_n, miss_fill_inhibit_n, tag_clear_all_n, cache_update_disable_n,
    output power_down_request_n, soft_reset_in_n, write_through_strap, flush_request_n,
    output scan_reset_n,
    input  transfer_ack_n
  );

endinterface : lcc_bus_if

`default_nettype wire

/* hw/lcc_host.sv */
/*
  Bus master end: turns user requests into bus cycles and drives the
  cache control pins. Assumes the device answers every cycle with an ack.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lcc_defines.svh"

module lcc_host
  import lcc_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_resetn,
  // User request
  input  wire logic              i_req,
  input  wire logic              i_write,
  input  wire logic              i_burst,
  input  wire logic              i_inhibit,
  input  wire logic [ADDR_W-1:0] i_addr,
  output logic                   o_busy,
  output logic                   o_done,
  // User control levels, active high
  input  wire logic              i_miss_fill_inhibit,
  input  wire logic              i_tag_clear_all,
  input  wire logic              i_cache_update_disable,
  input  wire logic              i_power_down_request,
  input  wire logic              i_soft_reset,
  input  wire logic              i_write_through_only,
  input  wire logic              i_flush_request,
  // Bus
  lcc_bus_if.host                bus
);

  lcc_hstate_t       state_r;
  logic              ts_r;
  logic              burst_r;
  logic              write_r;
  logic              ci_r;
  logic              done_r;
  logic [ADDR_W-1:0] addr_r;

  // ============================================================
  // Cycle issue
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_r <= LCC_HS_IDLE;
      ts_r    <= 1'b0;
      burst_r <= 1'b0;
      write_r <= 1'b0;
      ci_r    <= 1'b0;
      done_r  <= 1'b0;
      addr_r  <= '0;
    end
    else
    begin
      ts_r   <= 1'b0;
      done_r <= 1'b0;
      case (state_r)
        LCC_HS_IDLE:
        begin
          if (i_req)
          begin
            ts_r    <= 1'b1;
            burst_r <= i_burst;
            write_r <= i_write;
            ci_r    <= i_inhibit;
            addr_r  <= i_addr;
            state_r <= LCC_HS_WAIT;
          end
        end
        LCC_HS_WAIT:
        begin
          if (!bus.transfer_ack_n)
          begin
            done_r  <= 1'b1;
            ci_r    <= 1'b0;
            state_r <= LCC_HS_IDLE;
          end
        end
        default:
        begin
          state_r <= LCC_HS_IDLE;
        end
      endcase
    end
  end

  assign o_busy = (state_r != LCC_HS_IDLE);
  assign o_done = done_r;

  // ============================================================
  // Pins
  assign bus.transfer_start_n       = ~ts_r;
  assign bus.burst_status_n         = ~burst_r;
  assign bus.transfer_size          = burst_r ? `LCC_TSIZ_BURST : `LCC_TSIZ_BEAT;
  assign bus.transfer_type          = write_r ? `LCC_TT_WRITE : `LCC_TT_READ;
  assign bus.transfer_addr          = addr_r;
  assign bus.cache_inhibit_in_n     = ~ci_r;
  assign bus.miss_fill_inhibit_n    = ~i_miss_fill_inhibit;
  assign bus.tag_clear_all_n        = ~i_tag_clear_all;
  assign bus.cache_update_disable_n = ~i_cache_update_disable;
  assign bus.power_down_request_n   = ~i_power_down_request;
  assign bus.soft_reset_in_n        = ~i_soft_reset;
  assign bus.write_through_strap    = ~i_write_through_only;
  assign bus.flush_request_n        = ~i_flush_request;
  // Scan port unused, its reset kept asserted
  assign bus.scan_reset_n           = 1'b0;

endmodule : lcc_host

`default_nettype wire

/* testbench/lcc_bus_sva.sv */
/*
  Checker for the cache control link: watches the bus pins and device status.
  Assumes one clock, reset asynchronous and active low.
*/
`timescale 1ns/1ps
`default_nettype none

module lcc_bus_chk (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // Bus pins
  input wire logic transfer_start_n,
  input wire logic transfer_ack_n,
  input wire logic cache_inhibit_in_n,
  input wire logic miss_fill_inhibit_n,
  input wire logic tag_clear_all_n,
  input wire logic cache_update_disable_n,
  input wire logic power_down_request_n,
  input wire logic soft_reset_in_n,
  input wire logic write_through_strap,
  input wire logic scan_reset_n,
  // Device status
  input wire logic o_fill,
  input wire logic o_array_we,
  input wire logic o_hit,
  input wire logic o_ready,
  input wire logic o_write_through,
  input wire logic o_soft_reset,
  input wire logic o_flush_busy
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  // ============================================================
  // Cycles since power-down pin last released
  logic [7:0] wake_cnt_r;
  always_ff @(posedge i_clock or negedge i_resetn)
    if (!i_resetn) wake_cnt_r <= 8'hFF;
    else if (!power_down_request_n) wake_cnt_r <= 8'h00;
    else if (wake_cnt_r != 8'hFF) wake_cnt_r <= wake_cnt_r + 8'h01;

  // ============================================================
  // Properties
  sequence s_start_inh;
    !transfer_start_n ##1 !cache_inhibit_in_n;
  endsequence
  sequence s_srst_long;
    (!soft_reset_in_n) [*8] ##1 (!soft_reset_in_n) [*8];
  endsequence

  property p_ack_lat;
    $fell(transfer_ack_n) |-> ($past(transfer_start_n, 3) == 1'b0 || $past(transfer_start_n, 4) == 1'b0
      || $past(transfer_start_n, 7) == 1'b0);
  endproperty
  property p_no_fill_inh;
    s_start_inh |-> (!o_fill) [*6];
  endproperty
  property p_miss_inh;
    (!miss_fill_inhibit_n) [*3] |-> !o_fill;
  endproperty
  property p_tag_clr;
    (!tag_clear_all_n) [*3] |-> !o_ready && !o_fill && !o_flush_busy;
  endproperty
  property p_upd_dis;
    (!cache_update_disable_n) [*3] |-> !o_ready && $stable(o_hit);
  endproperty
  property p_pwr_dn;
    (!power_down_request_n) [*4] |-> !o_array_we;
  endproperty
  property p_wake;
    o_ready && power_down_request_n |-> wake_cnt_r >= 8'h4E;
  endproperty
  property p_srst_min;
    $rose(o_soft_reset) |-> $past(soft_reset_in_n, 7) == 1'b0;
  endproperty
  property p_srst_max;
    s_srst_long |-> o_soft_reset;
  endproperty
  property p_srst_idle;
    o_soft_reset [*2] |-> transfer_ack_n;
  endproperty
  property p_strap;
    $stable(write_through_strap) [*3] |-> o_write_through == !write_through_strap;
  endproperty
  property p_flush;
    $rose(o_flush_busy) |-> o_flush_busy [*4] ##1 !o_flush_busy;
  endproperty
  property p_scan_rst;
    !scan_reset_n;
  endproperty

  a_ack_lat: assert property (p_ack_lat) else $error("ack at wrong distance from start");
  a_no_fill_inh: assert property (p_no_fill_inh) else $error("fill despite cache inhibit");
  a_miss_inh: assert property (p_miss_inh) else $error("fill while miss fill inhibited");
  a_tag_clr: assert property (p_tag_clr) else $error("activity during tag clear");
  a_upd_dis: assert property (p_upd_dis) else $error("state moved while disabled");
  a_pwr_dn: assert property (p_pwr_dn) else $error("array write during power down");
  a_wake: assert property (p_wake) else $error("ready before wake interval");
  a_srst_min: assert property (p_srst_min) else $error("soft reset taken too early");
  a_srst_max: assert property (p_srst_max) else $error("soft reset not taken in time");
  a_srst_idle: assert property (p_srst_idle) else $error("ack during soft reset");
  a_strap: assert property (p_strap) else $error("write-through mode differs from strap");
  a_flush: assert property (p_flush) else $error("flush walk length wrong");
  a_scan_rst: assert property (p_scan_rst) else $error("scan reset not held low");

endmodule : lcc_bus_chk

`default_nettype wire

/* testbench/testbench.sv */
/*
  Self-checking bench: host and device joined by the link interface.
  Assumes a 20 MHz clock and a direct-mapped four-line reference model.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end

module testbench;
  logic       i_clock, i_resetn, req, wr, bst, inh, mfi, tclr, upd, pd, srst, wto, fl;
  logic [7:0] addr, aaddr, wbaddr;
  logic       done, we, fill, wb, hit, rdy, wt, srst_o, fbusy;
  int         n_mismatch, checked, cnt, fills, k;
  logic [31:0] seed;
  logic       clk_en = 1'b1;
  logic [7:0] expq[$];
  logic [5:0] tg[4];
  logic       vl[4], dt[4];

  lcc_bus_if #(.ADDR_W(8)) bus_if ();
  lcc_host #(.ADDR_W(8)) lcc_host_i (.i_clock(i_clock), .i_resetn(i_resetn), .i_req(req), .i_write(wr),
    .i_burst(bst), .i_inhibit(inh), .i_addr(addr), .o_busy(), .o_done(done), .i_miss_fill_inhibit(mfi),
    .i_tag_clear_all(tclr), .i_cache_update_disable(upd), .i_power_down_request(pd), .i_soft_reset(srst),
    .i_write_through_only(wto), .i_flush_request(fl), .bus(bus_if));
  lcc_device #(.ADDR_W(8), .LINES(4)) lcc_device_i (.i_clock(i_clock), .i_resetn(i_resetn), .bus(bus_if),
    .o_array_we(we), .o_array_addr(aaddr), .o_fill(fill), .o_writeback(wb), .o_wb_addr(wbaddr), .o_hit(hit),
    .o_ready(rdy), .o_write_through(wt), .o_soft_reset(srst_o), .o_flush_busy(fbusy));
  lcc_bus_chk lcc_bus_chk_i (.i_clock(i_clock), .i_resetn(i_resetn),
    .transfer_start_n(bus_if.transfer_start_n), .transfer_ack_n(bus_if.transfer_ack_n),
    .cache_inhibit_in_n(bus_if.cache_inhibit_in_n), .miss_fill_inhibit_n(bus_if.miss_fill_inhibit_n),
    .tag_clear_all_n(bus_if.tag_clear_all_n), .cache_update_disable_n(bus_if.cache_update_disable_n),
    .power_down_request_n(bus_if.power_down_request_n), .soft_reset_in_n(bus_if.soft_reset_in_n),
    .write_through_strap(bus_if.write_through_strap), .scan_reset_n(bus_if.scan_reset_n),
    .o_fill(fill), .o_array_we(we), .o_hit(hit),
    .o_ready(rdy), .o_write_through(wt), .o_soft_reset(srst_o), .o_flush_busy(fbusy));

  initial
  begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock & clk_en;
  end

  // ============================================================
  // Scoreboard: hit, edges from start to ack, fill beats
  always @(posedge i_clock)
  begin
    if (!bus_if.transfer_start_n)
    begin
      cnt = 0;
      fills = 0;
    end
    else
    begin
      cnt++;
      if (fill) fills++;
    end
    if (!bus_if.transfer_ack_n && expq.size() > 0) `CHK({hit, cnt[3:0], fills[2:0]}, expq.pop_front())
    else if (!bus_if.transfer_ack_n) `CHK(1'b0, 1'b1)
    if (we === 1'b1) `CHK(aaddr, addr)
  end

  task cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask : cyc

  task op(input logic w, input logic b, input logic ci, input logic [7:0] a);
    logic [1:0] ix;
    logic       h, fo;
    ix = a[1:0];
    h  = vl[ix] && tg[ix] == a[7:2];
    fo = !w && !h && !ci && !mfi;
    expq.push_back({h, (h || !fo) ? 4'h3 : (b ? 4'h7 : 4'h4), fo ? (b ? 3'h4 : 3'h1) : 3'h0});
    if (fo)
    begin
      vl[ix] = 1'b1;
      tg[ix] = a[7:2];
      dt[ix] = 1'b0;
    end
    if (w && h && !wto) dt[ix] = 1'b1;
    @(posedge i_clock);
    req  <= 1'b1;
    wr   <= w;
    bst  <= b;
    inh  <= ci;
    addr <= a;
    @(posedge i_clock);
    req <= 1'b0;
    for (k = 0; k < 20 && done !== 1'b1; k++)
    begin
      @(posedge i_clock);
      #1;
    end
    `CHK(k < 20, 1'b1)
    @(posedge i_clock);
  endtask : op

  task run(input int n);
    logic [31:0] r;
    repeat (n)
    begin
      r = $random(seed);
      op(r[0], r[1], r[2] & r[3], {4'h0, r[7:4]});
    end
  endtask : run

  task flush_chk;
    int n, e, j;
    n = 0;
    j = 0;
    e = dt[0] + dt[1] + dt[2] + dt[3];
    fl <= 1'b1;
    for (k = 0; k < 16; k++)
    begin
      @(posedge i_clock);
      if (k == 3) fl <= 1'b0;
      #1;
      n += wb;
      if (wb === 1'b1)
      begin
        while (j < 3 && !dt[j]) j++;
        `CHK(wbaddr, {tg[j], 2'(j)})
        j++;
      end
    end
    `CHK(n, e)
    vl = '{default: 1'b0};
    dt = '{default: 1'b0};
    @(posedge i_clock);
  endtask : flush_chk

  task conclude;
    $display("Counts: checked %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  // ============================================================
  // Watchdog: about 900 cycles of work, wide margin
  initial
  begin
    #1ms;
    n_mismatch++;
    conclude();
  end

  initial
  begin
    {req, wr, bst, inh, mfi, tclr, upd, pd, srst, wto, fl, addr} = '0;
    i_resetn = 1'b0;
    seed = 32'hE727F548;
    vl = '{default: 1'b0};
    dt = '{default: 1'b0};
    cyc(16);
    i_resetn <= 1'b1;
    cyc(2);
    run(24);
    flush_chk();
    $display("Test copy-back traffic and flush done");
    wto <= 1'b1;
    cyc(3);
    `CHK(wt, 1'b1)
    run(16);
    flush_chk();
    wto <= 1'b0;
    cyc(3);
    `CHK(wt, 1'b0)
    $display("Test write-through strap done");
    mfi <= 1'b1;
    cyc(3);
    run(12);
    mfi <= 1'b0;
    cyc(3);
    $display("Test miss fill inhibit done");
    run(8);
    tclr <= 1'b1;
    fl   <= 1'b1;
    cyc(4);
    fl <= 1'b0;
    #1;
    `CHK(rdy, 1'b0)
    cyc(3);
    tclr <= 1'b0;
    vl = '{default: 1'b0};
    dt = '{default: 1'b0};
    cyc(3);
    run(8);
    $display("Test tag clear done");
    upd <= 1'b1;
    cyc(3);
    #1;
    `CHK(rdy, 1'b0)
    cyc(1);
    upd <= 1'b0;
    cyc(3);
    run(4);
    $display("Test update disable done");
    pd <= 1'b1;
    cyc(6);
    // Clock stopped at a rising edge and held low; it restarts half a period out of its old phase
    clk_en = 1'b0;
    #510;
    clk_en = 1'b1;
    cyc(1);
    pd <= 1'b0;
    for (k = 0; k < 200 && rdy !== 1'b1; k++)
    begin
      @(posedge i_clock);
      #1;
    end
    `CHK(k >= 80 && k <= 86, 1'b1)
    run(4);
    $display("Test power down done");
    srst <= 1'b1;
    for (k = 0; k < 30 && srst_o !== 1'b1; k++)
    begin
      @(posedge i_clock);
      #1;
    end
    `CHK(k >= 8 && k <= 16, 1'b1)
    cyc(10);
    srst <= 1'b0;
    cyc(4);
    run(6);
    $display("Test soft reset done");
    conclude();
  end

endmodule : testbench

`default_nettype wire
